// File: common/spt_pkg.sv
// constants and types shared by the serial program and tx clocking block
`default_nettype none
package spt_pkg;
    // serial word and latch selection
    localparam int unsigned SPT_WORD_W = 32;
    localparam int unsigned SPT_NUM_LATCH = 4;
    localparam logic [1:0] SPT_SEL_REF = 2'h0;
    localparam logic [1:0] SPT_SEL_FREQ = 2'h1;
    localparam logic [1:0] SPT_SEL_MOD = 2'h2;
    localparam logic [1:0] SPT_SEL_FUNC = 2'h3;
    // field positions inside the latches
    localparam int unsigned SPT_CLKDIV_LSB = 19;
    localparam int unsigned SPT_CLKDIV_W = 4;
    localparam int unsigned SPT_XOSC_DIS_BIT = 18;
    localparam int unsigned SPT_CLKBUF_BIT = 4;
    localparam int unsigned SPT_MODE_LSB = 2;
    localparam int unsigned SPT_MODE_W = 3;
    localparam int unsigned SPT_RATE_LSB = 8;
    localparam int unsigned SPT_HALF_W = 16;
    localparam int unsigned SPT_MUXSEL_LSB = 28;
    localparam int unsigned SPT_MUXSEL_W = 3;
    // latch values after power-up: divide-by-16, buffer on, oscillator on
    localparam logic [31:0] SPT_REF_DEF = 32'h0040_0000;
    localparam logic [31:0] SPT_FREQ_DEF = 32'h0000_0001;
    localparam logic [31:0] SPT_MOD_DEF = 32'h0000_1902;
    localparam logic [31:0] SPT_FUNC_DEF = 32'h0000_0013;
    // modulation modes
    typedef enum logic [2:0] {
        SPT_FSK = 3'b000,
        SPT_GFSK = 3'b001,
        SPT_ASK = 3'b010,
        SPT_OOK = 3'b011,
        SPT_GOOK = 3'b101
    } spt_mode_t;
    // status multiplexer selections
    typedef enum logic [2:0] {
        SPT_MUX_LOW = 3'b000,
        SPT_MUX_LOCK = 3'b001,
        SPT_MUX_REG_READY = 3'b010,
        SPT_MUX_VMON = 3'b011,
        SPT_MUX_HIGH = 3'b100
    } spt_mux_t;
    // transmit clock states
    typedef enum logic [0:0] {
        SPT_TX_IDLE = 1'b0,
        SPT_TX_RUN = 1'b1
    } spt_tx_t;
    // bus register byte offsets
    localparam logic [7:0] SPT_OFF_REF = 8'h00;
    localparam logic [7:0] SPT_OFF_FREQ = 8'h04;
    localparam logic [7:0] SPT_OFF_MOD = 8'h08;
    localparam logic [7:0] SPT_OFF_FUNC = 8'h0C;
    localparam logic [7:0] SPT_OFF_IRQ_ST = 8'h10;
    localparam logic [7:0] SPT_OFF_IRQ_MASK = 8'h14;
    localparam logic [7:0] SPT_OFF_STATE = 8'h18;
    // interrupt bits
    localparam int unsigned SPT_IRQ_W = 4;
    localparam int unsigned SPT_IRQ_LOAD = 0;
    localparam int unsigned SPT_IRQ_TXBIT = 1;
    localparam int unsigned SPT_IRQ_LOCK = 2;
    localparam int unsigned SPT_IRQ_PDN = 3;
    localparam logic [SPT_IRQ_W-1:0] SPT_IRQ_MASK_DEF = 4'h0;
endpackage
`default_nettype wire

// File: common/spt_div_if.sv
// control and output bundle of one enable-based clock divider
`default_nettype none
interface spt_div_if;
    logic run;
    logic [spt_pkg::SPT_HALF_W-1:0] half;
    logic level;
    logic rise;
    logic fall;
    modport ctl(output run, output half, input level, input rise, input fall);
    modport div(input run, input half, output level, output rise, output fall);
endinterface
`default_nettype wire

// File: verilog/spt_clk_div.sv
// divider that toggles a level every half-period count of hclk cycles
`default_nettype none
module spt_clk_div
    import spt_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    spt_div_if.div d
);
    typedef struct packed {
        logic [SPT_HALF_W-1:0] cnt;
        logic level;
        logic rise;
        logic fall;
    } spt_div_st_t;

    spt_div_st_t st;
    spt_div_st_t next_st;
    logic [SPT_HALF_W-1:0] limit;

    // a half count of zero behaves like one
    assign limit = (d.half == '0) ? '0 : d.half - 1'b1;

    // count, toggle and flag each edge; equal high and low times
    always_comb begin
        next_st = st;
        next_st.rise = 1'b0;
        next_st.fall = 1'b0;
        if (!d.run) begin
            next_st.cnt = '0;
            next_st.level = 1'b0;
        end else if (st.cnt >= limit) begin
            next_st.cnt = '0;
            next_st.level = ~st.level;
            next_st.rise = ~st.level;
            next_st.fall = st.level;
        end else begin
            next_st.cnt = st.cnt + 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign d.level = st.level;
    assign d.rise = st.rise;
    assign d.fall = st.fall;
endmodule
`default_nettype wire

// File: verilog/spt_top.sv
// serial load port, latches, tx bit clock, clock out and status mux
//
// What this block does
// - serial clock rise shifts data into 32 bits
// - word arrives msb first, low two bits select
// - load strobe rise copies word to latch
// - chip enable low powers down, clears values
// - bit clock frequency equals configured data rate
// - device samples tx data on rising edge
// - status output can show pll lock
// - status output offers regulator ready, voltage monitor
// - clock output is reference divided, 50:50
// - clock divide even 2 to 30, default 16
// - clock buffer enable bit set at power-up
// - oscillator runs while disable bit low
//
// Local design decisions: the register addresses and the AHB-Lite interface to the registers.
`default_nettype none
module spt_top
    import spt_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic irq,
    input wire logic serial_clock,
    input wire logic serial_data,
    input wire logic load_strobe,
    input wire logic chip_enable,
    input wire logic tx_bit_in,
    input wire logic pll_lock_in,
    input wire logic regulator_ready_in,
    input wire logic voltage_monitor_in,
    output logic tx_bit_clock,
    output logic tx_bit_sampled,
    output logic tx_bit_valid,
    output logic status_mux_output,
    output logic divided_ref_clock_out,
    output logic crystal_osc_enable,
    output logic power_down
);
    import spt_pkg::*;

    typedef struct packed {
        logic [SPT_NUM_LATCH-1:0][SPT_WORD_W-1:0] latch;
        logic [SPT_WORD_W-1:0] shreg;
        logic sclk_q;
        logic load_q;
        logic ce_q;
        logic lock_q;
        spt_tx_t tx;
        logic tx_bit;
        logic tx_valid;
        logic [SPT_IRQ_W-1:0] irq_st;
        logic [SPT_IRQ_W-1:0] irq_mask;
        logic wr_pend;
        logic [7:0] wr_off;
        logic [31:0] rdata;
        logic mux_out;
        logic irq;
    } spt_st_t;

    spt_st_t st;
    spt_st_t next_st;

    spt_div_if ref_div();
    spt_div_if bit_div();

    logic sclk_rise;
    logic load_rise;
    logic addr_ok;
    logic gaussian;
    spt_mode_t mode;
    spt_mux_t mux_sel;
    logic [SPT_CLKDIV_W-1:0] clkdiv_field;
    logic [SPT_HALF_W-1:0] rate_half;
    logic clkbuf_en;
    logic xosc_dis_n;
    logic [SPT_IRQ_W-1:0] events;
    logic [SPT_IRQ_W-1:0] w1c;
    logic [31:0] rd_value;

    // pins are synchronous to hclk, so one stored copy finds the edges
    assign sclk_rise = serial_clock & ~st.sclk_q;
    assign load_rise = load_strobe & ~st.load_q;

    // configuration fields taken from the latches
    assign mode = spt_mode_t'(st.latch[SPT_SEL_MOD][SPT_MODE_LSB +: SPT_MODE_W]);
    assign rate_half = st.latch[SPT_SEL_MOD][SPT_RATE_LSB +: SPT_HALF_W];
    assign mux_sel = spt_mux_t'(st.latch[SPT_SEL_FUNC][SPT_MUXSEL_LSB +: SPT_MUXSEL_W]);
    assign clkbuf_en = st.latch[SPT_SEL_FUNC][SPT_CLKBUF_BIT];
    assign clkdiv_field = st.latch[SPT_SEL_REF][SPT_CLKDIV_LSB +: SPT_CLKDIV_W];
    assign xosc_dis_n = st.latch[SPT_SEL_REF][SPT_XOSC_DIS_BIT];
    assign gaussian = (mode == SPT_GFSK) || (mode == SPT_GOOK);

    // clock out divider: half period equals the field, ratio twice it
    assign ref_div.run = chip_enable & clkbuf_en & ~xosc_dis_n;
    assign ref_div.half = {{(SPT_HALF_W-SPT_CLKDIV_W){1'b0}}, clkdiv_field};

    // bit clock divider: one period per transmitted bit, stopped at once by power-down
    assign bit_div.run = (st.tx == SPT_TX_RUN) & chip_enable;
    assign bit_div.half = rate_half;

    spt_clk_div u_ref_div (
        .hclk(hclk),
        .hresetn(hresetn),
        .d(ref_div)
    );

    spt_clk_div u_bit_div (
        .hclk(hclk),
        .hresetn(hresetn),
        .d(bit_div)
    );

    // bus address phase decode
    assign addr_ok = hsel & hready & htrans[1];

    // read value chosen in the address phase, held in a flip-flop
    always_comb begin
        rd_value = 32'h0000_0000;
        case (haddr[7:0])
            SPT_OFF_REF: rd_value = st.latch[SPT_SEL_REF];
            SPT_OFF_FREQ: rd_value = st.latch[SPT_SEL_FREQ];
            SPT_OFF_MOD: rd_value = st.latch[SPT_SEL_MOD];
            SPT_OFF_FUNC: rd_value = st.latch[SPT_SEL_FUNC];
            SPT_OFF_IRQ_ST: rd_value = {{(32-SPT_IRQ_W){1'b0}}, st.irq_st};
            SPT_OFF_IRQ_MASK: rd_value = {{(32-SPT_IRQ_W){1'b0}}, st.irq_mask};
            SPT_OFF_STATE: rd_value = {26'h000_0000, st.mux_out, st.tx_bit, st.lock_q,
                                       bit_div.level, st.tx == SPT_TX_RUN, st.ce_q};
            default: rd_value = 32'h0000_0000;
        endcase
    end

    // events that set sticky status bits
    always_comb begin
        events = '0;
        events[SPT_IRQ_LOAD] = load_rise & chip_enable;
        events[SPT_IRQ_TXBIT] = bit_div.rise;
        events[SPT_IRQ_LOCK] = st.lock_q ^ pll_lock_in;
        events[SPT_IRQ_PDN] = st.ce_q & ~chip_enable;
    end

    // write-one-to-clear mask from the data phase of a status write
    assign w1c = (st.wr_pend && st.wr_off == SPT_OFF_IRQ_ST) ? hwdata[SPT_IRQ_W-1:0] : '0;

    // next state of the whole block
    always_comb begin
        next_st = st;
        next_st.sclk_q = serial_clock;
        next_st.load_q = load_strobe;
        next_st.ce_q = chip_enable;
        next_st.lock_q = pll_lock_in;
        next_st.tx_valid = 1'b0;

        // serial shift register and latch load
        if (!chip_enable) begin
            // power-down drops every programmed value
            next_st.shreg = '0;
            next_st.latch[SPT_SEL_REF] = SPT_REF_DEF;
            next_st.latch[SPT_SEL_FREQ] = SPT_FREQ_DEF;
            next_st.latch[SPT_SEL_MOD] = SPT_MOD_DEF;
            next_st.latch[SPT_SEL_FUNC] = SPT_FUNC_DEF;
        end else begin
            if (sclk_rise) begin
                // msb first, so new bits enter at the bottom
                next_st.shreg = {st.shreg[SPT_WORD_W-2:0], serial_data};
            end
            // only a strobe rise touches the latches
            if (load_rise) begin
                for (int i = 0; i < SPT_NUM_LATCH; i++) begin
                    if (st.shreg[1:0] == 2'(i)) begin
                        next_st.latch[i] = st.shreg;
                    end
                end
            end
        end

        // transmit bit clock state machine
        case (st.tx)
            SPT_TX_IDLE: begin
                if (chip_enable && gaussian) begin
                    next_st.tx = SPT_TX_RUN;
                end
            end
            SPT_TX_RUN: begin
                if (!chip_enable || !gaussian) begin
                    next_st.tx = SPT_TX_IDLE;
                end
            end
            default: begin
                next_st.tx = SPT_TX_IDLE;
            end
        endcase

        // sample host data at the rising bit clock edge, mid-bit
        // a rise in the first power-down cycle still samples with its valid pulse; otherwise power-down clears the bit
        if (bit_div.rise) begin
            next_st.tx_bit = tx_bit_in;
            next_st.tx_valid = 1'b1;
        end else if (!chip_enable) begin
            next_st.tx_bit = 1'b0;
        end

        // status multiplexer
        case (mux_sel)
            SPT_MUX_LOW: next_st.mux_out = 1'b0;
            SPT_MUX_LOCK: next_st.mux_out = pll_lock_in;
            SPT_MUX_REG_READY: next_st.mux_out = regulator_ready_in;
            SPT_MUX_VMON: next_st.mux_out = voltage_monitor_in;
            SPT_MUX_HIGH: next_st.mux_out = 1'b1;
            default: next_st.mux_out = 1'b0;
        endcase
        if (!chip_enable) begin
            next_st.mux_out = 1'b0;
        end

        // bus write takes effect in the data phase
        if (st.wr_pend && st.wr_off == SPT_OFF_IRQ_MASK) begin
            next_st.irq_mask = hwdata[SPT_IRQ_W-1:0];
        end
        next_st.wr_pend = addr_ok & hwrite;
        next_st.wr_off = haddr[7:0];
        if (addr_ok && !hwrite) begin
            next_st.rdata = rd_value;
        end

        // sticky status: a new event beats a clear in the same cycle
        next_st.irq_st = (st.irq_st & ~w1c) | events;
        next_st.irq = |(next_st.irq_st & next_st.irq_mask);
    end

    // the single state register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '0;
            st.latch[SPT_SEL_REF] <= SPT_REF_DEF;
            st.latch[SPT_SEL_FREQ] <= SPT_FREQ_DEF;
            st.latch[SPT_SEL_MOD] <= SPT_MOD_DEF;
            st.latch[SPT_SEL_FUNC] <= SPT_FUNC_DEF;
            st.tx <= SPT_TX_IDLE;
            st.irq_mask <= SPT_IRQ_MASK_DEF;
        end else begin
            st <= next_st;
        end
    end

    // bus answers at once and always okay
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = st.rdata;
    assign irq = st.irq;

    // pin outputs
    assign tx_bit_clock = bit_div.level;
    assign tx_bit_sampled = st.tx_bit;
    assign tx_bit_valid = st.tx_valid;
    assign status_mux_output = st.mux_out;
    assign divided_ref_clock_out = ref_div.level;
    assign crystal_osc_enable = chip_enable & ~xosc_dis_n;
    assign power_down = ~chip_enable;
endmodule
`default_nettype wire

// File: tb/spt_props.sv
// checker for the serial program and tx clocking block
`default_nettype none
module spt_props (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic chip_enable,
    input wire logic tx_bit_in,
    input wire logic tx_bit_clock,
    input wire logic tx_bit_sampled,
    input wire logic tx_bit_valid,
    input wire logic status_mux_output,
    input wire logic divided_ref_clock_out,
    input wire logic crystal_osc_enable,
    input wire logic power_down
);
    timeunit 1ns;
    timeprecision 1ns;
    // single clock domain
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // power pins
    property p_pd_pin; power_down == !chip_enable; endproperty
    a_pd_pin: assert property (p_pd_pin) else $error("power down pin wrong");
    property p_osc_off; !chip_enable |-> !crystal_osc_enable; endproperty
    a_osc_off: assert property (p_osc_off) else $error("oscillator on in power down");
    // outputs stand still while powered down
    property p_quiet; !chip_enable [*2] |-> !tx_bit_clock && !status_mux_output; endproperty
    a_quiet: assert property (p_quiet) else $error("output active in power down");
    property p_div_quiet; !chip_enable [*2] |-> !divided_ref_clock_out; endproperty
    a_div_quiet: assert property (p_div_quiet) else $error("clock out active in power down");
    // bit clock starts only when powered
    property p_rise_ce; $rose(tx_bit_clock) |-> $past(chip_enable); endproperty
    a_rise_ce: assert property (p_rise_ce) else $error("bit clock rose while powered down");
    // each rise samples the data bit
    property p_valid_after; $rose(tx_bit_clock) |=> tx_bit_valid && tx_bit_sampled == $past(tx_bit_in); endproperty
    a_valid_after: assert property (p_valid_after) else $error("rise did not sample data");
    property p_valid_cause; tx_bit_valid |-> $past(tx_bit_clock) && !$past(tx_bit_clock, 2); endproperty
    a_valid_cause: assert property (p_valid_cause) else $error("sample without a rise");
    property p_valid_pulse; tx_bit_valid |=> !tx_bit_valid; endproperty
    a_valid_pulse: assert property (p_valid_pulse) else $error("two samples in a row");
endmodule
`default_nettype wire

// File: tb/spt_host_model.sv
// host model: serial word writer and tx data source
`default_nettype none
module spt_host_model #(
    parameter logic [15:0] PAT = 16'hB2D4
) (
    input wire logic hclk,
    input wire logic tx_bit_clock,
    output logic tx_bit_in,
    output logic serial_clock,
    output logic serial_data,
    output logic load_strobe
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] k = 4'h0;
    logic seen_hi = 1'b0;
    // next data bit is put out after each falling edge of the bit clock
    assign tx_bit_in = PAT[~k];
    always @(posedge hclk) begin
        seen_hi <= tx_bit_clock;
        if (seen_hi && !tx_bit_clock) begin
            k <= k + 4'h1;
        end
    end
    // serial lines idle low
    initial begin
        serial_clock = 1'b0;
        serial_data = 1'b0;
        load_strobe = 1'b0;
    end
    // one word msb first, then an optional load strobe
    task automatic send_word(input logic [31:0] w, input logic strobe);
        for (int i = 31; i >= 0; i--) begin
            @(posedge hclk);
            serial_data <= w[i];
            @(posedge hclk);
            serial_clock <= 1'b1;
            repeat (2) @(posedge hclk);
            serial_clock <= 1'b0;
        end
        @(posedge hclk);
        serial_data <= ~w[0];
        load_strobe <= strobe;
        repeat (2) @(posedge hclk);
        load_strobe <= 1'b0;
    endtask
endmodule
`default_nettype wire

// File: tb/test_serial_program_and_tx_clocking.sv
// testbench for the serial program and tx clocking block
`default_nettype none
module test_serial_program_and_tx_clocking;
    timeunit 1ns;
    timeprecision 1ns;
    import spt_pkg::*;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, chip_enable = 1'b1;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic pll_lock_in = 1'b0, regulator_ready_in = 1'b0, voltage_monitor_in = 1'b0;
    logic hreadyout, hresp, irq, tx_bit_clock, tx_bit_sampled, tx_bit_valid, tx_bit_in;
    logic status_mux_output, divided_ref_clock_out, crystal_osc_enable, power_down;
    logic serial_clock, serial_data, load_strobe;
    logic [31:0] defs [4];
    spt_mode_t modes [5];
    int err_total = 0, samples_checked = 0, cyc = 0, r;
    always #10 hclk = ~hclk;
    spt_top DUT (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .irq(irq), .serial_clock(serial_clock), .serial_data(serial_data),
        .load_strobe(load_strobe), .chip_enable(chip_enable), .tx_bit_in(tx_bit_in),
        .pll_lock_in(pll_lock_in), .regulator_ready_in(regulator_ready_in),
        .voltage_monitor_in(voltage_monitor_in), .tx_bit_clock(tx_bit_clock),
        .tx_bit_sampled(tx_bit_sampled), .tx_bit_valid(tx_bit_valid), .status_mux_output(status_mux_output),
        .divided_ref_clock_out(divided_ref_clock_out), .crystal_osc_enable(crystal_osc_enable),
        .power_down(power_down)
    );
    spt_host_model host (.hclk(hclk), .tx_bit_clock(tx_bit_clock), .tx_bit_in(tx_bit_in),
        .serial_clock(serial_clock), .serial_data(serial_data), .load_strobe(load_strobe));
    // compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // closing report
    task automatic summarize();
        $display("checks=%0d errors=%0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // one ahb single transfer: address phase, then data phase
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= 2'b10;
        hwrite <= wr;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
        logic [31:0] x;
        ahb(1'b1, a, v, x);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        ahb(1'b0, a, 32'h0000_0000, v);
        chk(v, exp);
    endtask
    // high and low time of the bit clock or the divided clock
    function automatic logic sg(input logic s);
        return s ? tx_bit_clock : divided_ref_clock_out;
    endfunction
    task automatic meas(input logic s, input int half);
        int hi;
        int lo;
        hi = 0;
        lo = 0;
        while (sg(s)) @(posedge hclk);
        while (!sg(s)) @(posedge hclk);
        while (sg(s)) begin
            hi++;
            @(posedge hclk);
        end
        while (!sg(s)) begin
            lo++;
            @(posedge hclk);
        end
        chk(hi, half);
        chk(lo, half);
    endtask
    // cycle ceiling against hangs
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            summarize();
        end
    end
    // main sequence
    initial begin
        defs = '{SPT_REF_DEF, SPT_FREQ_DEF, SPT_MOD_DEF, SPT_FUNC_DEF};
        modes = '{SPT_GFSK, SPT_GOOK, SPT_FSK, SPT_ASK, SPT_OOK};
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        // power-up values; latches are closed to bus writes
        for (int l = 0; l < 4; l++) begin
            bus_wr(8'(l * 4), 32'hFFFF_FFFF);
            rd_chk(8'(l * 4), defs[l]);
        end
        rd_chk(8'h20, 32'h0000_0000);
        chk(crystal_osc_enable, 1'b1);
        meas(1'b0, 8);
        // shifting alone keeps the latch, the strobe loads it
        host.send_word(32'h0078_0000, 1'b0);
        rd_chk(SPT_OFF_REF, SPT_REF_DEF);
        host.send_word(32'h0078_0000, 1'b1);
        rd_chk(SPT_OFF_REF, 32'h0078_0000);
        meas(1'b0, 15);
        host.send_word(32'h1234_5671, 1'b1);
        rd_chk(SPT_OFF_FREQ, 32'h1234_5671);
        host.send_word(32'h0044_0000, 1'b1);
        chk(crystal_osc_enable, 1'b0);
        // interrupt raised, masked, raised again, cleared
        for (int l = 0; l < 4; l++) begin
            bus_wr(l < 3 ? SPT_OFF_IRQ_MASK : SPT_OFF_IRQ_ST, {31'h0000_0000, l != 1});
            repeat (2) @(posedge hclk);
            chk(irq, l == 0 || l == 2);
        end
        // status output selections against one-hot sources
        for (int m = 0; m < 5; m++) begin
            host.send_word({1'b0, m[2:0], 28'h000_0013}, 1'b1);
            for (int j = 0; j < 3; j++) begin
                {voltage_monitor_in, regulator_ready_in, pll_lock_in} <= 3'b001 << j;
                repeat (3) @(posedge hclk);
                chk(status_mux_output, m == 4 || m == j + 1);
            end
        end
        // bit clock: sampled bits, period, and which modes run it
        host.send_word(32'h0000_0306, 1'b1);
        for (int n = 0; n < 16; n++) begin
            while (tx_bit_valid !== 1'b1) @(posedge hclk);
            chk(tx_bit_sampled, host.PAT[15 - n]);
            @(posedge hclk);
        end
        meas(1'b1, 3);
        for (int m = 0; m < 5; m++) begin
            host.send_word({8'h00, 16'h0003, 3'b000, modes[m], 2'b10}, 1'b1);
            repeat (10) @(posedge hclk);
            r = 0;
            repeat (24) begin
                @(posedge hclk);
                r += int'(tx_bit_clock === 1'b1);
            end
            chk(r > 0, m < 2);
        end
        // power down refuses words and brings back the defaults
        chip_enable <= 1'b0;
        repeat (3) @(posedge hclk);
        chk(power_down, 1'b1);
        chk(crystal_osc_enable, 1'b0);
        host.send_word(32'h0008_0000, 1'b1);
        chip_enable <= 1'b1;
        for (int l = 0; l < 4; l++) begin
            rd_chk(8'(l * 4), defs[l]);
        end
        bus_wr(SPT_OFF_IRQ_MASK, 32'h0000_0008);
        repeat (2) @(posedge hclk);
        chk(irq, 1'b1);
        host.send_word(32'h0008_0000, 1'b1);
        meas(1'b0, 1);
        summarize();
    end
endmodule
bind spt_top spt_props u_props (
    .hclk(hclk), .hresetn(hresetn), .chip_enable(chip_enable), .tx_bit_in(tx_bit_in),
    .tx_bit_clock(tx_bit_clock), .tx_bit_sampled(tx_bit_sampled), .tx_bit_valid(tx_bit_valid),
    .status_mux_output(status_mux_output), .divided_ref_clock_out(divided_ref_clock_out),
    .crystal_osc_enable(crystal_osc_enable), .power_down(power_down)
);
`default_nettype wire
